// file: design/rtcs_readout.sv
// top of the remote temperature and current sense readout: registers, scheduler, results
//
// Local design decision: the plain strobed port.
module rtcs_readout
   import rtcs_pkg::*;
(
   input  wire logic                   clk_in,
   input  wire logic                   rst_n_in,
   input  wire logic [ADDR_W-1:0]      reg_addr_in,
   input  wire logic [RD_W-1:0]        reg_wdata_in,
   input  wire logic                   reg_wr_in,
   input  wire logic                   reg_rd_in,
   output logic      [RD_W-1:0]        reg_rdata_out,
   output logic                        conv_start_out,
   output logic      [2:0]             conv_chan_out,
   input  wire logic                   conv_done_in,
   input  wire logic [DATA_W-1:0]      conv_data_in,
   output logic                        remote_pnp_collector_ground_out,
   output logic                        loop_enable_out,
   output logic      [CS_N*DATA_W-1:0] dac_code_out
);
   import rtcs_pkg::*;

   logic [7:0]        cfg_a_q;
   logic [7:0]        cfg_b_q;
   logic [7:0]        chsel_q;
   logic [DATA_W-1:0] target_q [CS_N];
   logic [DATA_W-1:0] rt1_q;
   logic [DATA_W-1:0] rt2_q;
   logic [DATA_W-1:0] cs_res [CS_N];
   logic [DATA_W-1:0] dac_w [CS_N];
   logic [5:0]        pend_q;
   logic [5:0]        pend_d;
   logic [5:0]        pend_set;
   logic [5:0]        pend_clr;
   logic [7:0]        rt_cnt_q;
   logic [7:0]        filt_cnt_q;
   logic              rt_next_q;
   logic              step_tick;
   logic              run;
   logic              rt1_en;
   logic              rt2_en;
   logic              rt_due;
   logic              publish;
   logic [2:0]        pick;
   logic              pick_ok;
   logic [CS_N-1:0]   cs_valid;
   logic [7:0]        wr_idx;
   rtcs_state_e       state_q;

   assign run    = cfg_b_q[CFGB_RUN_BIT];
   assign rt1_en = chsel_q[CHSEL_RT1_BIT];
   assign rt2_en = chsel_q[CHSEL_RT2_BIT];
   assign wr_idx = reg_addr_in - ADDR_TARGET0;

   // register writes
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         cfg_a_q <= CFGA_RST;
         cfg_b_q <= CFGB_RST;
         chsel_q <= CHSEL_RST;
      end else if (reg_wr_in) begin
         case (reg_addr_in)
            ADDR_CFG_A: cfg_a_q <= reg_wdata_in[7:0];
            ADDR_CFG_B: cfg_b_q <= reg_wdata_in[7:0];
            ADDR_CHSEL: chsel_q <= reg_wdata_in[7:0];
            default:    ;
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < CS_N; i++) begin
            target_q[i] <= TARGET_RST;
         end
      end else if (reg_wr_in && wr_idx < 8'(CS_N)) begin
         target_q[wr_idx[1:0]] <= reg_wdata_in[DATA_W-1:0];
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         remote_pnp_collector_ground_out <= 1'b0;
         loop_enable_out                 <= 1'b0;
      end else begin
         remote_pnp_collector_ground_out <= cfg_b_q[CFGB_PNP_BIT];
         loop_enable_out                 <= cfg_a_q[CFGA_LOOP_BIT];
      end
   end

   rtcs_step_timer #(
      .PERIOD (STEP_CYCLES)
   ) u_step (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .run_in   (run),
      .tick_out (step_tick)
   );

   // remote sensors alternate, one every half of the total update time
   assign rt_due = step_tick && (rt_cnt_q >= rtcs_rt_half(cfg_a_q[CFGA_RUPD_LSB +: 3]) - 8'h01);

   always_ff @(posedge clk_in) begin
      if (!rst_n_in || !run) begin
         rt_cnt_q <= 8'h00;
      end else if (rt_due) begin
         rt_cnt_q <= 8'h00;
      end else if (step_tick) begin
         rt_cnt_q <= rt_cnt_q + 8'h01;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rt_next_q <= 1'b0;
      end else if (rt_due) begin
         rt_next_q <= ~rt_next_q;
      end
   end

   // filter result is published once per filter update time
   assign publish = step_tick &&
                    (filt_cnt_q >= rtcs_filt_steps(cfg_a_q[CFGA_FILT_LSB +: 3]) - 8'h01);

   always_ff @(posedge clk_in) begin
      if (!rst_n_in || !run) begin
         filt_cnt_q <= 8'h00;
      end else if (publish) begin
         filt_cnt_q <= 8'h00;
      end else if (step_tick) begin
         filt_cnt_q <= filt_cnt_q + 8'h01;
      end
   end

   // pending conversions; a new request wins over a completion clear
   always_comb begin
      pend_set = 6'h00;
      if (step_tick && chsel_q[CHSEL_CS_BIT]) begin
         pend_set[3:0] = 4'hF;
      end
      if (rt_due) begin
         if ((!rt_next_q && rt1_en) || (rt_next_q && !rt2_en && rt1_en)) begin
            pend_set[CH_RT1] = 1'b1;
         end else if (rt2_en) begin
            pend_set[CH_RT2] = 1'b1;
         end
      end
      pend_clr = 6'h00;
      if (state_q == ST_WAIT && conv_done_in) begin
         pend_clr[conv_chan_out] = 1'b1;
      end
      pend_d = (pend_q & ~pend_clr) | pend_set;
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         pend_q <= 6'h00;
      end else begin
         pend_q <= pend_d;
      end
   end

   always_comb begin
      pick    = 3'h0;
      pick_ok = 1'b0;
      for (int i = 5; i >= 0; i--) begin
         if (pend_q[i]) begin
            pick    = 3'(i);
            pick_ok = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state_q        <= ST_IDLE;
         conv_start_out <= 1'b0;
         conv_chan_out  <= 3'h0;
      end else begin
         conv_start_out <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (pick_ok) begin
                  conv_chan_out <= pick;
                  state_q       <= ST_REQ;
               end
            end
            ST_REQ: begin
               conv_start_out <= 1'b1;
               state_q        <= ST_WAIT;
            end
            ST_WAIT: begin
               if (conv_done_in) begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   always_comb begin
      cs_valid = '0;
      if (state_q == ST_WAIT && conv_done_in && !conv_chan_out[2]) begin
         cs_valid[conv_chan_out[1:0]] = 1'b1;
      end
   end

   // temperature codes kept as 12-bit two's complement, 0.25 C per step
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rt1_q <= '0;
         rt2_q <= '0;
      end else if (state_q == ST_WAIT && conv_done_in) begin
         if (conv_chan_out == CH_RT1) begin
            rt1_q <= conv_data_in;
         end
         if (conv_chan_out == CH_RT2) begin
            rt2_q <= conv_data_in;
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < CS_N; g++) begin : g_cs
         rtcs_cs_chan u_chan (
            .clk_in          (clk_in),
            .rst_n_in        (rst_n_in),
            .k_shift_in      (rtcs_filt_shift(cfg_a_q[CFGA_FILT_LSB +: 3])),
            .loop_en_in      (cfg_a_q[CFGA_LOOP_BIT]),
            .target_in       (target_q[g]),
            .sample_in       (conv_data_in),
            .sample_valid_in (cs_valid[g]),
            .publish_in      (publish),
            .result_out      (cs_res[g]),
            .dac_out         (dac_w[g])
         );
         assign dac_code_out[g*DATA_W +: DATA_W] = dac_w[g];
      end
   endgenerate

   // read data valid in the cycle after the strobe, zero otherwise
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || !reg_rd_in) begin
         reg_rdata_out <= '0;
      end else begin
         case (reg_addr_in)
            ADDR_CFG_A:          reg_rdata_out <= {8'h00, cfg_a_q};
            ADDR_CFG_B:          reg_rdata_out <= {8'h00, cfg_b_q};
            ADDR_CHSEL:          reg_rdata_out <= {8'h00, chsel_q};
            ADDR_CS_RES0:        reg_rdata_out <= {4'h0, cs_res[0]};
            ADDR_CS_RES0 + 8'h1: reg_rdata_out <= {4'h0, cs_res[1]};
            ADDR_CS_RES0 + 8'h2: reg_rdata_out <= {4'h0, cs_res[2]};
            ADDR_CS_RES0 + 8'h3: reg_rdata_out <= {4'h0, cs_res[3]};
            ADDR_RT_RES1:        reg_rdata_out <= {4'h0, rt1_q};
            ADDR_RT_RES2:        reg_rdata_out <= {4'h0, rt2_q};
            ADDR_TARGET0:        reg_rdata_out <= {4'h0, target_q[0]};
            ADDR_TARGET0 + 8'h1: reg_rdata_out <= {4'h0, target_q[1]};
            ADDR_TARGET0 + 8'h2: reg_rdata_out <= {4'h0, target_q[2]};
            ADDR_TARGET0 + 8'h3: reg_rdata_out <= {4'h0, target_q[3]};
            default:             reg_rdata_out <= '0;
         endcase
      end
   end

   sequence s_wr_pnp;
      reg_wr_in && reg_addr_in == ADDR_CFG_B;
   endsequence

   sequence s_rt1_done;
      state_q == ST_WAIT && conv_done_in && conv_chan_out == CH_RT1;
   endsequence

   AST_PNP: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      s_wr_pnp ##1 !reg_wr_in |=> remote_pnp_collector_ground_out == $past(reg_wdata_in[0], 2))
      else $error("ground-collector output does not follow its bit");
   AST_RT1_SKIP: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      rt_due && !rt1_en |=> !pend_q[CH_RT1] || $past(pend_q[CH_RT1]))
      else $error("disabled remote sensor was scheduled");
   AST_RT_STORE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      s_rt1_done |=> rt1_q == $past(conv_data_in))
      else $error("remote result not stored");
   AST_RT_LIMIT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      rt_cnt_q < rtcs_rt_half(cfg_a_q[CFGA_RUPD_LSB +: 3]) || !$stable(cfg_a_q)
      || !$past(run))
      else $error("remote step count beyond update time");
   AST_START_SEQ: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      conv_start_out |-> ($past(state_q) == ST_REQ) ##1 !conv_start_out)
      else $error("conversion start not a single pulse");
   AST_PUB_STEP: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      publish |-> step_tick)
      else $error("filter published off a step");
   // filter step count never passes the selected update time
   AST_FILT_LIMIT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      filt_cnt_q < rtcs_filt_steps(cfg_a_q[CFGA_FILT_LSB +: 3]) || !$stable(cfg_a_q)
      || !$past(run))
      else $error("filter step count beyond update time");
   AST_RD_CFGA: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      reg_rd_in && reg_addr_in == ADDR_CFG_A && !reg_wr_in |=> reg_rdata_out[7:0] == $past(cfg_a_q))
      else $error("configuration read back wrong");
   AST_LOOP_OUT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !cfg_a_q[CFGA_LOOP_BIT] [*2] |-> !loop_enable_out)
      else $error("loop enable output set in open loop");
endmodule : rtcs_readout

// file: pkg/rtcs_pkg.sv
// constants, field layout, timing and lookups for the remote temperature and current sense readout
// How it works
// - ground-collector bit selects PNP wiring for both
// - disabled remote sensor is skipped, no result
// - remote results stored as 12-bit two's complement
// - update select code sets remote update time
// - open loop stores current results straight binary
// - current code scales as code times 0.2/4096
// - closed loop adjusts one DAC per channel
// - filter field enables first order recursive filter
// - filter code sets K and update time
// - temperature LSB 0.25 C, MSB means negative
package rtcs_pkg;
   localparam int          DATA_W        = 12;
   localparam int          RD_W          = 16;
   localparam int          ADDR_W        = 8;
   localparam int          CS_N          = 4;
   localparam logic [7:0]  ADDR_CFG_A    = 8'h10;
   localparam logic [7:0]  ADDR_CFG_B    = 8'h11;
   localparam logic [7:0]  ADDR_CHSEL    = 8'h12;
   localparam logic [7:0]  ADDR_CS_RES0  = 8'h29;
   localparam logic [7:0]  ADDR_RT_RES1  = 8'h2E;
   localparam logic [7:0]  ADDR_RT_RES2  = 8'h2F;
   localparam logic [7:0]  ADDR_TARGET0  = 8'h30;
   localparam int          CFGA_FILT_LSB = 0;
   localparam int          CFGA_RUPD_LSB = 3;
   localparam int          CFGA_LOOP_BIT = 6;
   localparam int          CFGB_PNP_BIT  = 0;
   localparam int          CFGB_RUN_BIT  = 1;
   localparam int          CHSEL_CS_BIT  = 0;
   localparam int          CHSEL_RT1_BIT = 1;
   localparam int          CHSEL_RT2_BIT = 2;
   localparam logic [7:0]  CFGA_RST      = 8'h00;
   localparam logic [7:0]  CFGB_RST      = 8'h00;
   localparam logic [7:0]  CHSEL_RST     = 8'h07;
   localparam logic [11:0] TARGET_RST    = 12'h000;
   localparam logic [11:0] DAC_RST       = 12'h000;
   localparam logic [11:0] DAC_MAX       = 12'hFFF;
   localparam logic [2:0]  CH_RT1        = 3'h4;
   localparam logic [2:0]  CH_RT2        = 3'h5;
   localparam int          FRAC_W        = 4;
   localparam int          CLK_HZ        = 20_000_000;
   localparam int          STEP_US       = 200;
   localparam int          STEP_CYCLES   = CLK_HZ / 1_000_000 * STEP_US;
   localparam int          RT_MS_A       = 16;
   localparam int          RT_MS_B       = 18;
   localparam int          RT_MS_C       = 26;
   localparam int          RT_MS_D       = 50;
   localparam int          RT_MS_E       = 98;
   localparam int          FILT_US_1     = 200;
   localparam int          FILT_US_2     = 3400;
   localparam int          FILT_US_4     = 6600;
   localparam int          FILT_US_8     = 13000;
   localparam int          FILT_US_16    = 25600;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_REQ  = 3'b010,
      ST_WAIT = 3'b100
   } rtcs_state_e;

   // steps between two remote conversions: half of the total for both sensors
   function automatic logic [7:0] rtcs_rt_half(input logic [2:0] code);
      int ms;
      case (code)
         3'h2:    ms = RT_MS_B;
         3'h3:    ms = RT_MS_C;
         3'h4:    ms = RT_MS_D;
         3'h5:    ms = RT_MS_E;
         default: ms = RT_MS_A;
      endcase
      return 8'(ms * 1000 / STEP_US / 2);
   endfunction : rtcs_rt_half

   function automatic logic [7:0] rtcs_filt_steps(input logic [2:0] code);
      int us;
      case (code)
         3'h1:    us = FILT_US_2;
         3'h2:    us = FILT_US_4;
         3'h3:    us = FILT_US_8;
         3'h4:    us = FILT_US_16;
         default: us = FILT_US_1;
      endcase
      return 8'(us / STEP_US);
   endfunction : rtcs_filt_steps

   // log2 of K; invalid codes fall back to K=1
   function automatic logic [2:0] rtcs_filt_shift(input logic [2:0] code);
      return (code > 3'h4) ? 3'h0 : code;
   endfunction : rtcs_filt_shift
endpackage : rtcs_pkg

// file: design/rtcs_step_timer.sv
// interleave step timer: one tick pulse per step while running
module rtcs_step_timer #(
   parameter int PERIOD = 4000
) (
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   input  wire logic run_in,
   output logic      tick_out
);
   logic [12:0] cnt_q;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in || !run_in) begin
         cnt_q    <= 13'h0000;
         tick_out <= 1'b0;
      end else if (cnt_q == 13'(PERIOD - 1)) begin
         cnt_q    <= 13'h0000;
         tick_out <= 1'b1;
      end else begin
         cnt_q    <= cnt_q + 13'h0001;
         tick_out <= 1'b0;
      end
   end

   AST_TICK_GAP: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      tick_out |=> !tick_out [*8])
      else $error("step tick repeated too soon");
endmodule : rtcs_step_timer

// file: design/rtcs_cs_chan.sv
// one current sense channel: recursive filter, result register and loop controller
module rtcs_cs_chan
   import rtcs_pkg::*;
(
   input  wire logic              clk_in,
   input  wire logic              rst_n_in,
   input  wire logic [2:0]        k_shift_in,
   input  wire logic              loop_en_in,
   input  wire logic [DATA_W-1:0] target_in,
   input  wire logic [DATA_W-1:0] sample_in,
   input  wire logic              sample_valid_in,
   input  wire logic              publish_in,
   output logic      [DATA_W-1:0] result_out,
   output logic      [DATA_W-1:0] dac_out
);
   localparam int ACC_W = DATA_W + FRAC_W;
   logic        [ACC_W-1:0] acc_q;
   logic signed [ACC_W:0]   diff;
   logic signed [ACC_W:0]   step;

   always_comb begin
      diff = $signed({1'b0, sample_in, {FRAC_W{1'b0}}}) - $signed({1'b0, acc_q});
      step = diff >>> k_shift_in;
   end

   // y moves toward the sample by 1/K of the gap
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         acc_q <= '0;
      end else if (sample_valid_in) begin
         acc_q <= ACC_W'($signed({1'b0, acc_q}) + step);
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         result_out <= '0;
      end else if (publish_in) begin
         result_out <= acc_q[ACC_W-1:FRAC_W];
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         dac_out <= DAC_RST;
      end else if (loop_en_in && sample_valid_in) begin
         if (sample_in < target_in && dac_out != DAC_MAX) begin
            dac_out <= dac_out + 12'h001;
         end else if (sample_in > target_in && dac_out != 12'h000) begin
            dac_out <= dac_out - 12'h001;
         end
      end
   end

   AST_K1_PASS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      sample_valid_in && k_shift_in == 3'h0 |=> acc_q[ACC_W-1:FRAC_W] == $past(sample_in))
      else $error("K of one does not pass the sample");
   AST_PUBLISH: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      publish_in |=> result_out == $past(acc_q[ACC_W-1:FRAC_W]))
      else $error("result not published from filter");
   AST_LOOP_OFF: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !loop_en_in |=> $stable(dac_out))
      else $error("dac moved in open loop");
   AST_LOOP_UP: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      loop_en_in && sample_valid_in && sample_in < target_in && dac_out != DAC_MAX
      |=> dac_out == $past(dac_out) + 12'h001)
      else $error("dac did not step up below target");
endmodule : rtcs_cs_chan

// file: verification/rtcs_conv_model.sv
// converter and sensor front end model answering the readout's conversion requests
module rtcs_conv_model
   import rtcs_pkg::*;
(
   input  wire logic              clk_in,
   input  wire logic              rst_n_in,
   input  wire logic              start_in,
   input  wire logic [2:0]        chan_in,
   input  wire logic              slow_in,
   input  wire logic              clr_in,
   output logic                   done_out,
   output logic      [DATA_W-1:0] data_out,
   output logic      [7:0]        cnt_out [6]
);
   timeunit 1ns;
   timeprecision 100ps;

   logic       busy_q;
   logic [4:0] wait_q;
   logic [2:0] chan_q;

   function automatic logic [DATA_W-1:0] sense_code(input logic [2:0] ch);
      case (ch)
         3'h4:    return 12'hF24;
         3'h5:    return 12'h064;
         default: return 12'h100 + 12'(ch) * 12'h111;
      endcase
   endfunction : sense_code

   initial begin
      done_out = 1'b0;
      data_out = 12'h5A5;
      busy_q   = 1'b0;
   end

   always @(posedge clk_in) begin
      done_out <= 1'b0;
      // outside a result the data lines carry no stable value
      data_out <= ~data_out;
      if (!rst_n_in || clr_in) begin
         for (int i = 0; i < 6; i++) cnt_out[i] <= 8'h00;
      end
      if (!rst_n_in) begin
         busy_q <= 1'b0;
      end else if (start_in) begin
         busy_q <= 1'b1;
         wait_q <= slow_in ? 5'h14 : 5'h01;
         chan_q <= chan_in;
      end else if (busy_q) begin
         if (wait_q == 5'h00) begin
            busy_q           <= 1'b0;
            done_out         <= 1'b1;
            data_out         <= sense_code(chan_q);
            cnt_out[chan_q]  <= cnt_out[chan_q] + 8'h01;
         end else begin
            wait_q <= wait_q - 5'h01;
         end
      end
   end
endmodule : rtcs_conv_model

// file: verification/rtcs_readout_tb.sv
// self-checking testbench of the remote temperature and current sense readout
module rtcs_readout_tb
   import rtcs_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic                   clk_in;
   logic                   rst_n;
   logic [ADDR_W-1:0]      reg_addr;
   logic [RD_W-1:0]        reg_wdata;
   logic                   reg_wr;
   logic                   reg_rd;
   logic [RD_W-1:0]        reg_rdata;
   logic                   conv_start;
   logic [2:0]             conv_chan;
   logic                   conv_done;
   logic [DATA_W-1:0]      conv_data;
   logic                   pnp_ground;
   logic                   loop_en;
   logic [CS_N*DATA_W-1:0] dac_code;
   logic                   slow;
   logic                   clr;
   logic [7:0]             cnt [6];
   int                     error_cnt;
   int                     checks_done;
   int                     cycles;

   rtcs_readout u_dut (
      .clk_in                          (clk_in),
      .rst_n_in                        (rst_n),
      .reg_addr_in                     (reg_addr),
      .reg_wdata_in                    (reg_wdata),
      .reg_wr_in                       (reg_wr),
      .reg_rd_in                       (reg_rd),
      .reg_rdata_out                   (reg_rdata),
      .conv_start_out                  (conv_start),
      .conv_chan_out                   (conv_chan),
      .conv_done_in                    (conv_done),
      .conv_data_in                    (conv_data),
      .remote_pnp_collector_ground_out (pnp_ground),
      .loop_enable_out                 (loop_en),
      .dac_code_out                    (dac_code)
   );

   rtcs_conv_model u_conv (
      .clk_in   (clk_in),
      .rst_n_in (rst_n),
      .start_in (conv_start),
      .chan_in  (conv_chan),
      .slow_in  (slow),
      .clr_in   (clr),
      .done_out (conv_done),
      .data_out (conv_data),
      .cnt_out  (cnt)
   );

   always #25 clk_in = ~clk_in;

   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : stop_test

   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 40000) begin
         error_cnt++;
         $display("unexpected cycle limit reached");
         stop_test();
      end
   end

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_in);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_in);
      reg_wr    <= 1'b0;
   endtask : reg_write

   task automatic rd_chk(input string what, input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk_in);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_in);
      reg_rd   <= 1'b0;
      @(posedge clk_in);
      chk(what, exp, reg_rdata);
   endtask : rd_chk

   function automatic logic [15:0] cs_exp(input int ch);
      return 16'h0100 + 16'(ch) * 16'h0111;
   endfunction : cs_exp

   task automatic test_reset;
      chk("dac codes", 16'h0000, {15'h0000, |dac_code});
      chk("pnp ground", 16'h0000, {15'h0000, pnp_ground});
      chk("loop enable", 16'h0000, {15'h0000, loop_en});
      rd_chk("cfg a", ADDR_CFG_A, 16'h0000);
      rd_chk("cfg b", ADDR_CFG_B, 16'h0000);
      rd_chk("chan select", ADDR_CHSEL, 16'h0007);
      rd_chk("cs result", ADDR_CS_RES0, 16'h0000);
      rd_chk("remote result 1", ADDR_RT_RES1, 16'h0000);
      rd_chk("remote result 2", ADDR_RT_RES2, 16'h0000);
      rd_chk("target 0", ADDR_TARGET0, 16'h0000);
      $display("test_reset done");
   endtask : test_reset

   task automatic test_regs;
      reg_write(ADDR_CFG_B, 16'h0001);
      repeat (2) @(posedge clk_in);
      chk("pnp ground set", 16'h0001, {15'h0000, pnp_ground});
      reg_write(ADDR_CFG_B, 16'h0000);
      repeat (2) @(posedge clk_in);
      chk("pnp ground clear", 16'h0000, {15'h0000, pnp_ground});
      for (int c = 0; c < 6; c++) begin
         reg_write(ADDR_CFG_A, 16'(c << 3));
         rd_chk("remote update code", ADDR_CFG_A, 16'(c << 3));
      end
      for (int c = 0; c < 5; c++) begin
         reg_write(ADDR_CFG_A, 16'(c));
         rd_chk("filter code", ADDR_CFG_A, 16'(c));
      end
      reg_write(ADDR_CFG_A, 16'h0040);
      repeat (2) @(posedge clk_in);
      chk("loop enable", 16'h0001, {15'h0000, loop_en});
      reg_write(ADDR_CFG_A, 16'h0000);
      reg_write(ADDR_CS_RES0, 16'h0ABC);
      rd_chk("cs result read only", ADDR_CS_RES0, 16'h0000);
      reg_write(ADDR_RT_RES1, 16'h0123);
      rd_chk("remote result read only", ADDR_RT_RES1, 16'h0000);
      reg_write(8'h55, 16'hFFFF);
      rd_chk("unmapped", 8'h55, 16'h0000);
      reg_write(ADDR_TARGET0, 16'hFABC);
      rd_chk("target width", ADDR_TARGET0, 16'h0ABC);
      $display("test_regs done");
   endtask : test_regs

   task automatic test_open_loop;
      slow <= 1'b1;
      reg_write(ADDR_CHSEL, 16'h0001);
      reg_write(ADDR_CFG_A, 16'h0000);
      reg_write(ADDR_CFG_B, 16'h0002);
      repeat (3 * STEP_CYCLES + 200) @(posedge clk_in);
      reg_write(ADDR_CFG_B, 16'h0000);
      repeat (100) @(posedge clk_in);
      for (int ch = 0; ch < CS_N; ch++) begin
         rd_chk("cs result", ADDR_CS_RES0 + 8'(ch), cs_exp(ch));
      end
      chk("cs requests seen", 16'h0001, {15'h0000, cnt[0] != 8'h00});
      chk("remote 1 requests", 16'h0000, {8'h00, cnt[4]});
      chk("remote 2 requests", 16'h0000, {8'h00, cnt[5]});
      chk("dac frozen", 16'h0000, {15'h0000, |dac_code});
      $display("test_open_loop done");
   endtask : test_open_loop

   task automatic test_closed_loop;
      slow <= 1'b0;
      reg_write(ADDR_TARGET0, 16'h0800);
      reg_write(ADDR_TARGET0 + 8'h01, 16'h0000);
      reg_write(ADDR_TARGET0 + 8'h02, cs_exp(2));
      reg_write(ADDR_TARGET0 + 8'h03, 16'h0FFF);
      reg_write(ADDR_CFG_A, 16'h0040);
      @(posedge clk_in);
      clr <= 1'b1;
      @(posedge clk_in);
      clr <= 1'b0;
      reg_write(ADDR_CFG_B, 16'h0002);
      repeat (2 * STEP_CYCLES + 200) @(posedge clk_in);
      reg_write(ADDR_CFG_B, 16'h0000);
      repeat (100) @(posedge clk_in);
      chk("samples seen", 16'h0001, {15'h0000, cnt[0] != 8'h00});
      chk("dac 0 rises", {8'h00, cnt[0]}, {4'h0, dac_code[11:0]});
      chk("dac 1 floor", 16'h0000, {4'h0, dac_code[23:12]});
      chk("dac 2 on target", 16'h0000, {4'h0, dac_code[35:24]});
      chk("dac 3 rises", {8'h00, cnt[3]}, {4'h0, dac_code[47:36]});
      $display("test_closed_loop done");
   endtask : test_closed_loop

   // remote sensing alone: current channels switched off for best accuracy
   task automatic test_cs_off;
      reg_write(ADDR_CHSEL, 16'h0006);
      @(posedge clk_in);
      clr <= 1'b1;
      @(posedge clk_in);
      clr <= 1'b0;
      reg_write(ADDR_CFG_B, 16'h0002);
      repeat (STEP_CYCLES + 200) @(posedge clk_in);
      reg_write(ADDR_CFG_B, 16'h0000);
      repeat (10) @(posedge clk_in);
      chk("cs off requests", 16'h0000, {8'h00, cnt[0] | cnt[1] | cnt[2] | cnt[3]});
      rd_chk("remote result kept", ADDR_RT_RES2, 16'h0000);
      $display("test_cs_off done");
   endtask : test_cs_off

   initial begin
      clk_in      = 1'b0;
      rst_n       = 1'b0;
      reg_addr    = 8'h00;
      reg_wdata   = 16'h0000;
      reg_wr      = 1'b0;
      reg_rd      = 1'b0;
      slow        = 1'b0;
      clr         = 1'b0;
      error_cnt   = 0;
      checks_done = 0;
      cycles      = 0;
      repeat (6) @(posedge clk_in);
      rst_n <= 1'b1;
      @(posedge clk_in);
      test_reset();
      test_regs();
      test_open_loop();
      test_closed_loop();
      test_cs_off();
      stop_test();
   end
endmodule : rtcs_readout_tb
